// >>> mgf_params.svh
// constants for the mode and global fault status block
`ifndef MGF_PARAMS_SVH
`define MGF_PARAMS_SVH
// -----------------------------------------------------------------
// clock and frame
// -----------------------------------------------------------------
`define MGF_CLK_MHZ         40
`define MGF_FRAME_BITS      24
// -----------------------------------------------------------------
// control word one field positions
// -----------------------------------------------------------------
`define MGF_CTL_ENABLE      23
`define MGF_CTL_REC_EIGHT   22
`define MGF_CTL_FIXED_A     21
`define MGF_CTL_REC_SEVEN   20
`define MGF_CTL_REC_SIX     19
`define MGF_CTL_FIXED_B     18
`define MGF_CTL_SELECT      0
`define MGF_CTL_SELECT_ONE  1'b1
// -----------------------------------------------------------------
// fault status word one field positions
// -----------------------------------------------------------------
`define MGF_ST_MARKER       23
`define MGF_ST_VS_OVER      22
`define MGF_ST_VS_UNDER     21
`define MGF_ST_TSD          20
`define MGF_ST_TW           19
`define MGF_ST_NOT_READY    18
`define MGF_ST_NO_ERROR     0
// -----------------------------------------------------------------
// reset values and timing
// -----------------------------------------------------------------
`define MGF_REC_EN_RESET    3'h0
`define MGF_SETTLE_US       50
`define MGF_SETTLE_CYC      (`MGF_SETTLE_US * `MGF_CLK_MHZ)
`define MGF_REC_DELAY_US    1000
`define MGF_REC_DELAY_CYC   (`MGF_REC_DELAY_US * `MGF_CLK_MHZ)
`endif

// >>> mgf_pkg.sv
// types shared by the mode and global fault status block
package mgf_pkg;
   // device operating mode
   typedef enum logic [1:0]
   {
      MGF_STANDBY = 2'b00,
      MGF_SETTLE  = 2'b01,
      MGF_ACTIVE  = 2'b10
   } mgf_mode_e;
   typedef logic [23:0] mgf_word_t;
endpackage : mgf_pkg

// >>> mgf_link_if.sv
// signals between the serial frame engine and the status core
`timescale 1ns/1ps
`default_nettype none
interface mgf_link_if;
   mgf_pkg::mgf_word_t rx_word;   // last shifted-in word
   logic               rx_done;   // 24 bits seen in this frame
   logic               rx_over;   // more than 24 bits seen
   mgf_pkg::mgf_word_t tx_word;   // status snapshot to shift out
   modport frame (output rx_word, output rx_done, output rx_over, input tx_word);
   modport core  (input rx_word, input rx_done, input rx_over, output tx_word);
endinterface : mgf_link_if
`default_nettype wire

// >>> mgf_spi_frame.sv
// serial frame engine on the link clock
`timescale 1ns/1ps
`default_nettype none
module mgf_spi_frame
(
   input  wire logic  i_spi_sck,
   input  wire logic  i_spi_csn,
   input  wire logic  i_spi_di,
   output logic       o_spi_do,
   output logic       o_spi_do_oe_n,
   mgf_link_if.frame  link
);
   logic [4:0]  bit_cnt_reg;
   logic [23:0] shift_reg;
   logic        do_reg;
   logic        done_reg;
   logic        over_reg;

   // -----------------------------------------------------------------
   // receive side
   // -----------------------------------------------------------------
   // count cleared while deselected; saturates at 25 to flag overlength
   always_ff @(posedge i_spi_sck or posedge i_spi_csn)
   begin
      if (i_spi_csn)
         bit_cnt_reg <= 5'h00;
      else if (bit_cnt_reg != 5'h19)
         bit_cnt_reg <= bit_cnt_reg + 5'h01;
   end

   // data path needs no reset, only read after a checked frame
   always_ff @(posedge i_spi_sck)
   begin
      shift_reg <= {shift_reg[22:0], i_spi_di};
   end

   // length flags held in flops, so the crossing never sees a decode glitch
   always_ff @(posedge i_spi_sck or posedge i_spi_csn)
   begin
      if (i_spi_csn)
      begin
         done_reg <= 1'b0;
         over_reg <= 1'b0;
      end
      else
      begin
         done_reg <= (bit_cnt_reg >= 5'h17);
         over_reg <= (bit_cnt_reg >= 5'h18);
      end
   end

   assign link.rx_word = shift_reg;
   assign link.rx_done = done_reg;
   assign link.rx_over = over_reg;

   // -----------------------------------------------------------------
   // transmit side, msb first, changes on falling edge
   // -----------------------------------------------------------------
   always_ff @(negedge i_spi_sck or posedge i_spi_csn)
   begin
      if (i_spi_csn)
         do_reg <= 1'b0;
      else if (bit_cnt_reg < 5'h18)
         do_reg <= link.tx_word[5'd23 - bit_cnt_reg];
      else
         do_reg <= 1'b0;
   end

   // first bit must stand before the first rising edge
   assign o_spi_do      = (bit_cnt_reg == 5'h00) ? link.tx_word[23] : do_reg;
   assign o_spi_do_oe_n = i_spi_csn;
endmodule : mgf_spi_frame
`default_nettype wire

// >>> mgf_status_ctrl.sv
// mode control and global fault status, control and status word one
//
// Behaviour
// [RULE1] writing enable one moves the device into active mode
// [RULE2] writing enable zero gives standby and clears every control bit
// [RULE3] after reset the device waits in standby until enabled
// [RULE4] status bit 23 always reads one; host rejects all-zero or all-one frames
// [RULE5] supply over or under voltage sets its bit and turns outputs off
// [RULE6] outputs return by themselves once the supply is normal again
// [RULE7] over-current sets that output's flag and turns the output off
// [RULE8] with recovery enabled the output retries after a delay
// [RULE9] one retry may still happen after recovery enable is cleared
// [RULE10] thermal shutdown sets its flag and turns every output off
// [RULE11] shutdown flag holds until the reset bit; outputs stay off meanwhile
// [RULE12] temperature warning flag in bit 19 holds until host clears it
// [RULE13] each standby to active switch starts a settle timer blocking outputs
// [RULE14] not-ready bit is high only while the settle timer runs
// [RULE15] bit 0 is the nor of status bits 1 to 22 of both words
// [RULE16] fixed bits ignored; control updates only on a full valid frame
`timescale 1ns/1ps
`default_nettype none
`include "mgf_params.svh"
module mgf_status_ctrl
#(
   parameter int REC_DELAY_CYCLES = `MGF_REC_DELAY_CYC
)
(
   input  wire logic        i_sys_clk,
   input  wire logic        i_sys_rst,
   input  wire logic        i_spi_sck,
   input  wire logic        i_spi_csn,
   input  wire logic        i_spi_di,
   output logic             o_spi_do,
   output logic             o_spi_do_oe_n,
   input  wire logic        i_vs_over,
   input  wire logic        i_vs_under,
   input  wire logic        i_thermal_shutdown,
   input  wire logic        i_temp_warning,
   input  wire logic [2:0]  i_over_current,
   input  wire logic        i_fault_reset,
   input  wire logic [17:1] i_status_low,
   input  wire logic        i_reg0_fault_any,
   output logic             o_active_mode,
   output logic             o_not_ready,
   output logic [2:0]       o_out_enable,
   output logic [2:0]       o_over_current_flag,
   output logic [2:0]       o_rec_enable
);
   localparam int SETTLE_CYC = `MGF_SETTLE_CYC;
   localparam int RW         = $clog2(REC_DELAY_CYCLES + 1);

   // -----------------------------------------------------------------
   // declarations
   // -----------------------------------------------------------------
   mgf_link_if link ();
   logic [9:0]          sync1_reg;
   logic [9:0]          sync2_reg;
   logic                csn_s, done_s, over_s, vs_over_s, vs_under_s, tsd_s, tw_s;
   logic [2:0]          oc_s;
   logic                csn_last_reg;
   logic                seen_done_reg;
   logic                seen_over_reg;
   logic                frame_end;
   logic                wr_valid;
   logic                wr_enable;
   mgf_pkg::mgf_mode_e  mode_reg;
   logic [11:0]         settle_cnt_reg;
   logic [2:0]          rec_en_reg;
   logic [2:0]          rec_en_next;
   logic [2:0]          rec_arm_reg;
   logic [2:0]          oc_off_reg;
   logic [2:0]          oc_flag_reg;
   logic [RW-1:0]       rec_cnt_reg;
   logic                rec_tick;
   logic                tsd_flag_reg;
   logic                tw_flag_reg;
   logic                vs_fault;
   logic                nor_bit;
   mgf_pkg::mgf_word_t  status_word;
   mgf_pkg::mgf_word_t  tx_snap_reg;

   // -----------------------------------------------------------------
   // link side engine
   // -----------------------------------------------------------------
   mgf_spi_frame u_frame
   (
      .i_spi_sck     (i_spi_sck),
      .i_spi_csn     (i_spi_csn),
      .i_spi_di      (i_spi_di),
      .o_spi_do      (o_spi_do),
      .o_spi_do_oe_n (o_spi_do_oe_n),
      .link          (link.frame)
   );

   // -----------------------------------------------------------------
   // two-flop synchronisers for pins and link-domain levels
   // -----------------------------------------------------------------
   always_ff @(posedge i_sys_clk)
   begin
      if (i_sys_rst)
      begin
         sync1_reg <= 10'h001;
         sync2_reg <= 10'h001;
      end
      else
      begin
         sync1_reg <= {i_over_current, i_temp_warning, i_thermal_shutdown, i_vs_under,
                       i_vs_over, link.rx_over, link.rx_done, i_spi_csn};
         sync2_reg <= sync1_reg;
      end
   end

   assign csn_s      = sync2_reg[0];
   assign done_s     = sync2_reg[1];
   assign over_s     = sync2_reg[2];
   assign vs_over_s  = sync2_reg[3];
   assign vs_under_s = sync2_reg[4];
   assign tsd_s      = sync2_reg[5];
   assign tw_s       = sync2_reg[6];
   assign oc_s       = sync2_reg[9:7];

   // -----------------------------------------------------------------
   // frame acceptance
   // -----------------------------------------------------------------
   // done and over drop with chip select, so they are caught during the frame
   always_ff @(posedge i_sys_clk)
   begin
      if (i_sys_rst)
      begin
         csn_last_reg  <= 1'b1;
         seen_done_reg <= 1'b0;
         seen_over_reg <= 1'b0;
      end
      else
      begin
         csn_last_reg  <= csn_s;
         seen_done_reg <= csn_s ? 1'b0 : (seen_done_reg | done_s);
         seen_over_reg <= csn_s ? 1'b0 : (seen_over_reg | over_s);
      end
   end

   assign frame_end = csn_s && !csn_last_reg;
   // exactly 24 bits addressed at word one, else discarded
   assign wr_valid  = frame_end && seen_done_reg && !seen_over_reg          // RULE16
                      && (link.rx_word[`MGF_CTL_SELECT] == `MGF_CTL_SELECT_ONE);
   assign wr_enable = link.rx_word[`MGF_CTL_ENABLE];

   // -----------------------------------------------------------------
   // mode state machine with charge pump settle timer
   // -----------------------------------------------------------------
   always_ff @(posedge i_sys_clk)
   begin
      if (i_sys_rst)
         mode_reg <= mgf_pkg::MGF_STANDBY;                               // RULE3
      else if (wr_valid && !wr_enable)
         mode_reg <= mgf_pkg::MGF_STANDBY;                               // RULE2
      else
      begin
         case (mode_reg)
            mgf_pkg::MGF_STANDBY:
               if (wr_valid && wr_enable)
                  mode_reg <= mgf_pkg::MGF_SETTLE;                       // RULE1 RULE13
            mgf_pkg::MGF_SETTLE:
               if (settle_cnt_reg == 12'(SETTLE_CYC - 1))
                  mode_reg <= mgf_pkg::MGF_ACTIVE;
            mgf_pkg::MGF_ACTIVE:
               mode_reg <= mgf_pkg::MGF_ACTIVE;
            default:
               mode_reg <= mgf_pkg::MGF_STANDBY;
         endcase
      end
   end

   // timer restarts on every entry into settle
   always_ff @(posedge i_sys_clk)
   begin
      if (i_sys_rst || mode_reg != mgf_pkg::MGF_SETTLE)
         settle_cnt_reg <= 12'h000;
      else
         settle_cnt_reg <= settle_cnt_reg + 12'h001;                     // RULE13
   end

   // -----------------------------------------------------------------
   // control bits; fixed bits 21 and 18 are never stored
   // -----------------------------------------------------------------
   always_comb
   begin
      rec_en_next = rec_en_reg;
      if (wr_valid)
         rec_en_next = wr_enable ? {link.rx_word[`MGF_CTL_REC_EIGHT],
                                    link.rx_word[`MGF_CTL_REC_SEVEN],
                                    link.rx_word[`MGF_CTL_REC_SIX]}
                                 : `MGF_REC_EN_RESET;                    // RULE2 RULE16
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_sys_rst)
         rec_en_reg <= `MGF_REC_EN_RESET;
      else
         rec_en_reg <= rec_en_next;
   end

   // -----------------------------------------------------------------
   // over-current handling and recovery
   // -----------------------------------------------------------------
   // one shared recovery phase for all outputs, like an internal clock
   always_ff @(posedge i_sys_clk)
   begin
      if (i_sys_rst || rec_tick)
         rec_cnt_reg <= '0;
      else
         rec_cnt_reg <= rec_cnt_reg + RW'(1);
   end
   assign rec_tick = (rec_cnt_reg == RW'(REC_DELAY_CYCLES - 1));

   // enable sampled at the phase, so a late clear may still allow one retry
   always_ff @(posedge i_sys_clk)
   begin
      if (i_sys_rst)
         rec_arm_reg <= 3'h0;
      else if (rec_tick)
         rec_arm_reg <= rec_en_reg;                                      // RULE9
   end

   // output latched off on over-current; retry at phase when armed
   always_ff @(posedge i_sys_clk)
   begin
      if (i_sys_rst || mode_reg == mgf_pkg::MGF_STANDBY)
         oc_off_reg <= 3'h0;
      else
         oc_off_reg <= oc_s | (oc_off_reg & ~(rec_tick ? rec_arm_reg : 3'h0)  // RULE7 RULE8
                               & ~{3{i_fault_reset}});
   end

   // sticky flag, a new event beats the clear
   always_ff @(posedge i_sys_clk)
   begin
      if (i_sys_rst)
         oc_flag_reg <= 3'h0;
      else
         oc_flag_reg <= oc_s | (oc_flag_reg & ~{3{i_fault_reset}});      // RULE7
   end

   // -----------------------------------------------------------------
   // thermal flags, set wins over clear
   // -----------------------------------------------------------------
   always_ff @(posedge i_sys_clk)
   begin
      if (i_sys_rst)
         tsd_flag_reg <= 1'b0;
      else
         tsd_flag_reg <= tsd_s | (tsd_flag_reg & !i_fault_reset);        // RULE10 RULE11
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_sys_rst)
         tw_flag_reg <= 1'b0;
      else
         tw_flag_reg <= tw_s | (tw_flag_reg & !i_fault_reset);           // RULE12
   end

   // -----------------------------------------------------------------
   // output gating; supply faults act live and release by themselves
   // -----------------------------------------------------------------
   assign vs_fault = vs_over_s | vs_under_s;                             // RULE5 RULE6
   always_ff @(posedge i_sys_clk)
   begin
      if (i_sys_rst)
         o_out_enable <= 3'h0;
      else if (mode_reg != mgf_pkg::MGF_ACTIVE || vs_fault || tsd_flag_reg) // RULE5 RULE10 RULE11
         o_out_enable <= 3'h0;
      else
         o_out_enable <= ~(oc_off_reg | oc_s);                           // RULE6 RULE7
   end

   assign o_active_mode       = (mode_reg != mgf_pkg::MGF_STANDBY);
   assign o_not_ready         = (mode_reg == mgf_pkg::MGF_SETTLE);       // RULE14
   assign o_over_current_flag = oc_flag_reg;
   assign o_rec_enable        = rec_en_reg;

   // -----------------------------------------------------------------
   // status word one, frozen while a frame is in progress
   // -----------------------------------------------------------------
   assign nor_bit = ~(vs_over_s | vs_under_s | tsd_flag_reg | tw_flag_reg   // RULE15
                      | o_not_ready | (|i_status_low) | i_reg0_fault_any);
   always_comb
   begin
      status_word                    = {1'b0, 5'h00, i_status_low, 1'b0};
      status_word[`MGF_ST_MARKER]    = 1'b1;                             // RULE4
      status_word[`MGF_ST_VS_OVER]   = vs_over_s;                        // RULE5
      status_word[`MGF_ST_VS_UNDER]  = vs_under_s;
      status_word[`MGF_ST_TSD]       = tsd_flag_reg;
      status_word[`MGF_ST_TW]        = tw_flag_reg;                      // RULE12
      status_word[`MGF_ST_NOT_READY] = o_not_ready;                      // RULE14
      status_word[`MGF_ST_NO_ERROR]  = nor_bit;
   end

   // the host must leave three system clocks between select and first edge
   always_ff @(posedge i_sys_clk)
   begin
      if (i_sys_rst)
         tx_snap_reg <= 24'h800000;
      else if (csn_s)
         tx_snap_reg <= status_word;
   end
   assign link.tx_word = tx_snap_reg;

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   sequence s_enable_write;
      wr_valid && wr_enable && mode_reg == mgf_pkg::MGF_STANDBY;
   endsequence
   sequence s_settling;
      o_not_ready [*8];
   endsequence

   chk_enable_settle: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // RULE1
      s_enable_write |=> s_settling ##0 (o_out_enable == 3'h0))
      else $error("enable write did not start settling");
   chk_standby_clear: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // RULE2
      (wr_valid && !wr_enable) |=> (!o_active_mode && o_rec_enable == 3'h0))
      else $error("disable write did not clear control");
   chk_reset_standby: assert property (@(posedge i_sys_clk) // RULE3
      i_sys_rst |=> (mode_reg == mgf_pkg::MGF_STANDBY && o_out_enable == 3'h0))
      else $error("not in standby after reset");
   chk_marker_bit: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // RULE4
      tx_snap_reg[`MGF_ST_MARKER] && (tx_snap_reg != 24'hFFFFFF))
      else $error("frame marker bit wrong");
   chk_supply_off: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // RULE5
      vs_fault |=> (o_out_enable == 3'h0))
      else $error("outputs on during supply fault");
   chk_supply_back: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // RULE6
      (mode_reg == mgf_pkg::MGF_ACTIVE && !vs_fault && !tsd_flag_reg
       && oc_off_reg == 3'h0 && oc_s == 3'h0) |=> (o_out_enable == 3'h7))
      else $error("outputs not restored");
   chk_oc_off: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // RULE7
      (oc_s != 3'h0) |=> ((o_out_enable & $past(oc_s)) == 3'h0)
                         && ((o_over_current_flag & $past(oc_s)) == $past(oc_s)))
      else $error("over-current output not off");
   chk_oc_retry: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // RULE8
      (rec_tick && oc_off_reg[0] && rec_arm_reg[0] && !oc_s[0]
       && mode_reg != mgf_pkg::MGF_STANDBY) |=> !oc_off_reg[0])
      else $error("recovery retry missing");
   chk_tsd_hold: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // RULE11
      (tsd_flag_reg && !i_fault_reset) |=> (tsd_flag_reg && o_out_enable == 3'h0))
      else $error("shutdown flag dropped without reset");
   chk_tw_sticky: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // RULE12
      tw_s |=> tw_flag_reg [*2] or (tw_flag_reg ##1 $past(i_fault_reset)))
      else $error("warning flag lost");
   chk_settle_len: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // RULE14
      $fell(o_not_ready) && o_active_mode |-> ($past(settle_cnt_reg) == 12'(SETTLE_CYC - 1)))
      else $error("settle time wrong");
   chk_nor_bit: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // RULE15
      status_word[`MGF_ST_NO_ERROR] == ~(|status_word[22:1] | i_reg0_fault_any))
      else $error("no-error bit wrong");
endmodule : mgf_status_ctrl
`default_nettype wire

// >>> mgf_host_model.sv
// serial master model standing in for the microcontroller
`timescale 1ns/1ps
`default_nettype none
module mgf_host_model
(
   output logic      o_sck,
   output logic      o_csn,
   output logic      o_di,
   input  wire logic i_do,
   input  wire logic i_do_oe_n
);
   // sck idles low and only runs inside a frame
   initial
   begin
      o_sck = 1'b0;
      o_csn = 1'b1;
      o_di  = 1'b0;
   end
   // one frame of n bits, msb first, 64 ns link period
   task automatic xfer(input logic [23:0] w, input int n, output logic [23:0] r);
      r = 24'h000000;
      o_csn = 1'b0;
      #100;
      for (int k = 0; k < n; k++)
      begin
         o_di = w[23 - k];
         #32 o_sck = 1'b1;
         r = {r[22:0], i_do & ~i_do_oe_n};
         #32 o_sck = 1'b0;
      end
      #50 o_csn = 1'b1;
      o_di = ~o_di; // released line shows the inverse, not a stale bit
      #100;
   endtask : xfer
endmodule : mgf_host_model
`default_nettype wire

// >>> testbench.sv
// self-checking bench for the mode and global fault status block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin bad_count++; \
   $display("[ERR] %0t %h %h", $time, (a), (b)); end end
module testbench;
   logic        clk = 1'b0, rst = 1'b1, sck, csn, di, sdo, oe_n;
   logic        vo = 1'b0, vu = 1'b0, thermal_shutdown_flag = 1'b0, tw = 1'b0, r0 = 1'b0, frst = 1'b0;
   logic [2:0]  oc = 3'h0, oen, ocf, rec;
   logic [16:0] low = 17'h00000;
   logic        act, nr;
   logic [23:0] rd, w;
   int          bad_count = 0, comparisons = 0;
   // 40 MHz system clock
   always #12.5 clk = ~clk;
   mgf_status_ctrl #(.REC_DELAY_CYCLES(16)) mgf_status_ctrl_inst
   (
      .i_sys_clk(clk), .i_sys_rst(rst), .i_spi_sck(sck), .i_spi_csn(csn), .i_spi_di(di),
      .o_spi_do(sdo), .o_spi_do_oe_n(oe_n), .i_vs_over(vo), .i_vs_under(vu),
      .i_thermal_shutdown(thermal_shutdown_flag), .i_temp_warning(tw), .i_over_current(oc),
      .i_fault_reset(frst), .i_status_low(low), .i_reg0_fault_any(r0),
      .o_active_mode(act), .o_not_ready(nr), .o_out_enable(oen),
      .o_over_current_flag(ocf), .o_rec_enable(rec)
   );
   mgf_host_model mgf_host_model_inst
   (
      .o_sck(sck), .o_csn(csn), .o_di(di), .i_do(sdo), .i_do_oe_n(oe_n)
   );
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1; // look at outputs once the edge's updates have settled
   endtask : cyc
   // frame, then wait out the four-cycle crossing with margin
   task automatic frame(input logic [23:0] v, input int n);
      mgf_host_model_inst.xfer(v, n, rd);
      cyc(6);
   endtask : frame
   // one-cycle pulse of the reset control bit
   task automatic clear_faults;
      @(posedge clk) frst <= 1'b1;
      @(posedge clk) frst <= 1'b0;
      cyc(5);
   endtask : clear_faults
   // expected status word from the flags {over, under, tsd, warn, not ready}
   function automatic logic [23:0] exp_st(input logic [4:0] f);
      return {1'b1, f, low, ~(|f | |low | r0)};
   endfunction : exp_st
   task automatic end_sim;
      if (bad_count == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : end_sim
   // watchdog well beyond the expected run
   initial
   begin
      #2000000;
      bad_count++;
      end_sim();
   end
   initial
   begin
      void'($urandom(72));
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      cyc(3);
      `CHK({act, nr, oen, ocf, rec, oe_n}, 12'h001);
      frame(24'h000001, 24);
      `CHK(rd, exp_st(5'h00));
      `CHK(rd !== 24'h000000 && rd !== 24'hFFFFFF, 1'b1);
      frame(24'hFC0001, 24);
      `CHK({act, nr, oen, rec}, 8'hC7);
      frame(24'hFC0001, 24);
      `CHK(rd, exp_st(5'h01));
      `CHK(oen, 3'h0);
      cyc(2000);
      `CHK({nr, oen}, 4'h7);
      for (int i = 0; i < 2; i++)
      begin
         @(posedge clk) {vo, vu} <= 2'b10 >> i;
         cyc(5);
         `CHK(oen, 3'h0);
         frame(24'hFC0001, 24);
         `CHK(rd, exp_st({2'b10 >> i, 3'b000}));
         @(posedge clk) {vo, vu} <= 2'b00;
         cyc(5);
         `CHK(oen, 3'h7);
      end
      @(posedge clk) oc <= 3'h1;
      cyc(5);
      `CHK({ocf, oen}, 6'h0E);
      @(posedge clk) oc <= 3'h0;
      cyc(48);
      `CHK({ocf, oen}, 6'h0F);
      clear_faults();
      `CHK(ocf, 3'h0);
      @(posedge clk) thermal_shutdown_flag <= 1'b1;
      cyc(5);
      `CHK(oen, 3'h0);
      @(posedge clk) {thermal_shutdown_flag, tw} <= 2'b01;
      cyc(5);
      @(posedge clk) tw <= 1'b0;
      cyc(40);
      `CHK(oen, 3'h0);
      frame(24'hFC0001, 24);
      `CHK(rd, exp_st(5'h06));
      clear_faults();
      `CHK(oen, 3'h7);
      frame(24'hFC0001, 24);
      `CHK(rd, exp_st(5'h00));
      frame(24'h000000, 24);
      `CHK({act, rec}, 4'hF);
      frame(24'h000001, 23);
      `CHK({act, rec}, 4'hF);
      // random control writes with random lower status inputs
      for (int i = 0; i < 8; i++)
      begin
         w = {1'b1, 5'($urandom), 17'($urandom), 1'b1};
         @(posedge clk)
         begin
            low <= 17'($urandom);
            r0 <= 1'($urandom);
         end
         cyc(4);
         frame(w, 24);
         `CHK(rec, {w[22], w[20], w[19]});
         `CHK(rd, exp_st(5'h00));
      end
      frame(24'h7C0001, 24);
      `CHK({act, nr, oen, rec}, 8'h00);
      frame(24'h800001, 24);
      `CHK({act, nr, oen}, 5'h18);
      // reset in mid-run, while settling, must give standby again
      @(posedge clk) rst <= 1'b1;
      cyc(2);
      @(posedge clk) rst <= 1'b0;
      cyc(3);
      `CHK({act, nr, oen, ocf, rec}, 11'h000);
      end_sim();
   end
endmodule : testbench
`default_nettype wire
